// File: rwsc_pkg.sv
// Contract
// [RL1] Hardware reset low returns all logic and registers to reset state. The code does not clear the power-on counter porCount on hwResetN.
// [RL2] Undriven hardware reset floats inactive; internal power-on reset then acts.
// [RL3] Host reads the device once before writes after power-up, reset or wake.
// [RL4] When enabled, a wake event asserts the wake indicator output. The code flags a wake event only in RWSC_SLEEP.
// [RL5] Wake indicator polarity and push-pull or open-drain drive are configurable.
// [RL6] A wake event or wake indicator alone never leaves power saving.
// [RL7] Power saving ends only on chip select with write strobe together.
// [RL8] Any host write in power saving, any data, wakes the device.
// [RL9] Host should wake the device by writing the byte-order test register.
// [RL10] Crossover auto detection follows its enable input; open means disabled.
// [RL11] Speed strap level is captured when reset releases.
// [RL12] Logic is timed from a 25MHz reference clock.
// [RL13] Strap 0: 10Mbps half, no autoneg; strap 1: 100Mbps half, autoneg.
// [RL14] Host write cycle is write strobe low while chip select low.
// [RL15] Strap defaults hold until next reset or software reprogramming.
`default_nettype none
package rwsc_pkg;
  localparam int REF_CLOCK_MHZ = 25;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS * REF_CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] POR_COUNT = 8'(POR_CYCLES);
  localparam logic RESET_SPEED = 1'b0;
  localparam logic RESET_DUPLEX = 1'b0;
  localparam logic RESET_AUTONEG = 1'b0;

  typedef struct packed {
    logic speed100;
    logic fullDuplex;
    logic autoNeg;
  } rwsc_link_s;

  typedef struct packed {
    logic enable;
    logic activeHigh;
    logic pushPull;
  } rwsc_wake_cfg_s;

  typedef enum logic [2:0] {
    RWSC_RESET = 3'h1,
    RWSC_ACTIVE = 3'h2,
    RWSC_SLEEP = 3'h4
  } rwsc_state_e;
endpackage
`default_nettype wire

// File: rwsc_reset_gen.sv
`default_nettype none
module rwsc_reset_gen
  import rwsc_pkg::*;
(
  // Clock and reset sources
  input wire logic clk,
  input wire logic srst,
  input wire logic hwResetN,
  // Combined reset
  output logic sysReset
);
  logic [7:0] porCount;
  logic [7:0] next_porCount;
  logic next_sysReset;

  // Power-on stretch: a floating reset pin reads high, so this counter covers power-up
  always_comb begin
    next_porCount = porCount;
    if (srst) begin
      next_porCount = 8'h00; // [RL2]
    end else if (porCount != POR_COUNT) begin
      next_porCount = porCount + 8'h01;
    end
    next_sysReset = srst || !hwResetN || (porCount != POR_COUNT); // [RL1]
  end

  always_ff @(posedge clk) begin
    porCount <= next_porCount;
    sysReset <= next_sysReset;
  end
endmodule
`default_nettype wire

// File: rwsc_top.sv
`default_nettype none
module rwsc_top
  import rwsc_pkg::*;
(
  // Clock and reset, clk is the 25MHz reference
  input wire logic clk,
  input wire logic srst,
  input wire logic hwResetN,
  // Host strobes
  input wire logic chipSelectN,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  // Straps
  input wire logic speedSel,
  input wire logic crossoverAutoEnable,
  // Configuration from software
  input wire rwsc_wake_cfg_s wakeCfg,
  input wire logic sleepRequest,
  input wire logic wakeEvent,
  input wire logic linkWrite,
  input wire rwsc_link_s linkWriteData,
  // Status
  output logic sysReset,
  output logic asleep,
  output logic writesEnabled,
  output rwsc_link_s linkSettings,
  output logic crossoverAuto,
  // Wake indicator pin
  output logic wakeIndicatorOut,
  output logic wakeIndicatorOeN
);
  logic rstInt;
  rwsc_state_e state;
  rwsc_state_e next_state;
  logic wakePending;
  logic next_wakePending;
  logic next_writesEnabled;
  rwsc_link_s next_linkSettings;
  logic next_wakeIndicatorOut;
  logic next_wakeIndicatorOeN;
  logic hostWrite;
  logic hostRead;
  logic next_asleep;
  logic next_sysReset;
  logic next_crossoverAuto;

  rwsc_reset_gen uReset (
    .clk(clk),
    .srst(srst),
    .hwResetN(hwResetN),
    .sysReset(rstInt)
  );

  assign hostWrite = !chipSelectN && !writeStrobeN; // [RL14]
  assign hostRead = !chipSelectN && !readStrobeN;

  always_comb begin
    next_state = state;
    next_wakePending = wakePending;
    next_writesEnabled = writesEnabled;
    next_linkSettings = linkSettings;
    unique case (state)
      RWSC_RESET: begin
        // Strap sampled on the first cycle out of reset
        next_linkSettings.speed100 = speedSel; // [RL11]
        next_linkSettings.fullDuplex = 1'b0; // [RL13]
        next_linkSettings.autoNeg = speedSel; // [RL13]
        next_state = RWSC_ACTIVE;
      end
      RWSC_ACTIVE: begin
        if (hostRead) begin
          next_writesEnabled = 1'b1; // [RL3]
        end
        if (linkWrite && writesEnabled) begin
          next_linkSettings = linkWriteData; // [RL15]
        end
        if (sleepRequest) begin
          next_state = RWSC_SLEEP;
          next_writesEnabled = 1'b0;
        end
      end
      RWSC_SLEEP: begin
        // Wake event only flags the pin; state stays asleep
        if (wakeEvent && wakeCfg.enable) begin
          next_wakePending = 1'b1; // [RL4] [RL6]
        end
        if (hostWrite) begin
          // Data and address ignored, any write wakes
          next_state = RWSC_ACTIVE; // [RL7] [RL8]
          next_wakePending = 1'b0;
          next_writesEnabled = 1'b0; // [RL3]
        end
      end
      default: begin
        next_state = RWSC_RESET;
      end
    endcase
    if (rstInt) begin
      next_state = RWSC_RESET; // [RL1]
      next_wakePending = 1'b0;
      next_writesEnabled = 1'b0;
      next_linkSettings = '{RESET_SPEED, RESET_DUPLEX, RESET_AUTONEG};
    end
    // Open-drain only pulls to the active level when that level is low
    next_wakeIndicatorOut = wakeCfg.activeHigh ? next_wakePending : !next_wakePending; // [RL5]
    if (wakeCfg.pushPull) begin
      next_wakeIndicatorOeN = 1'b0; // [RL5]
    end else begin
      next_wakeIndicatorOeN = !(next_wakePending ^ wakeCfg.activeHigh) ? 1'b1 : 1'b0;
    end
    next_asleep = (next_state == RWSC_SLEEP);
    next_sysReset = rstInt;
    next_crossoverAuto = rstInt ? 1'b0 : crossoverAutoEnable; // [RL10]
  end

  always_ff @(posedge clk) begin // [RL12]
    state <= next_state;
    wakePending <= next_wakePending;
    writesEnabled <= next_writesEnabled;
    linkSettings <= next_linkSettings;
    wakeIndicatorOut <= next_wakeIndicatorOut;
    wakeIndicatorOeN <= next_wakeIndicatorOeN;
    asleep <= next_asleep;
    sysReset <= next_sysReset;
    crossoverAuto <= next_crossoverAuto;
  end
endmodule
`default_nettype wire

// File: rwsc_top_chk.sv
`default_nettype none
module rwsc_top_chk
  import rwsc_pkg::*;
(
  input wire logic clk, srst, hwResetN, sysReset, asleep, writesEnabled,
  input wire logic chipSelectN, writeStrobeN, readStrobeN, speedSel, linkWrite,
  input wire rwsc_link_s linkSettings
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !hwResetN || sysReset);
  wire logic wr = !chipSelectN && !writeStrobeN;
  wire logic [2:0] strap = {speedSel, 1'b0, speedSel};
  property p_wk; asleep && wr |=> !asleep; endproperty
  a_wk: assert property (p_wk) else $error("wake");
  property p_st; asleep && !wr |=> asleep; endproperty
  a_st: assert property (p_st) else $error("stay");
  property p_sp; $fell(sysReset) |-> ##[1:3] linkSettings == strap; endproperty
  a_sp: assert property (p_sp) else $error("strap");
  // Strap load lands as reset drops, so the hold window starts after reset
  property p_hd; (!linkWrite && !sysReset) [*4] |=> $stable(linkSettings); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_rd; !asleep && !chipSelectN && !readStrobeN |=> writesEnabled; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_sl; $rose(asleep) |-> !writesEnabled; endproperty
  a_sl: assert property (p_sl) else $error("sleep");
  property p_rs; disable iff (1'b0) srst [*2] |=> !asleep && linkSettings == 3'h0; endproperty
  a_rs: assert property (p_rs) else $error("reset");
  // Power-on count keeps reset up well past the source
  property p_pr; disable iff (1'b0) $fell(srst) |-> sysReset [*8]; endproperty
  a_pr: assert property (p_pr) else $error("por");
  c_wk: cover property (asleep && wr);
  c_rd: cover property (linkWrite && writesEnabled);
  c_sp: cover property ($fell(sysReset) && speedSel);
endmodule
bind rwsc_top rwsc_top_chk i_chk(.*);
`default_nettype wire

// File: rwsc_host_model.sv
`default_nettype none
module rwsc_host_model (
  input wire logic clk,
  output logic chipSelectN = 1'b1, writeStrobeN = 1'b1, readStrobeN = 1'b1
);
  timeunit 1ns; timeprecision 1ps;
  // No address bus here; the target is kept so a wake write names the test word
  localparam logic [7:0] BYTE_TEST_ADDR = 8'h00;
  logic [7:0] lastAddr = 8'h00;
  // Released strobes sit high, as on the pulled-up bus
  task automatic access(input logic wr);
    @(negedge clk);
    if (wr) lastAddr = BYTE_TEST_ADDR;
    {chipSelectN, writeStrobeN, readStrobeN} = {1'b0, !wr, wr};
    @(negedge clk);
    {chipSelectN, writeStrobeN, readStrobeN} = 3'h7;
  endtask
endmodule
`default_nettype wire

// File: reset_wake_strap_control_tb_top.sv
`default_nettype none
module reset_wake_strap_control_tb_top;
  timeunit 1ns; timeprecision 1ps;
  import rwsc_pkg::*;
  logic clk = 0, srst = 1, hwResetN = 1, speedSel, crossoverAutoEnable, sleepRequest = 0;
  logic wakeEvent = 0, linkWrite = 0, chipSelectN, writeStrobeN, readStrobeN, sysReset;
  logic asleep, writesEnabled, crossoverAuto, wakeIndicatorOut, wakeIndicatorOeN;
  rwsc_link_s linkWriteData = 3'h0, linkSettings;
  rwsc_wake_cfg_s wakeCfg = 3'h0;
  int fail_count = 0, tests_run = 0;
  // Open-drain is only run active low, so one test covers both drives
  wire logic pinOn = !wakeIndicatorOeN && wakeIndicatorOut === wakeCfg.activeHigh;
  always #2 clk = ~clk;
  rwsc_host_model i_host(.*);
  rwsc_top i_rwsc_top(.*);
  task check(input logic [2:0] seen, want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    tick();
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  initial begin
    void'($urandom(64));
    for (int r = 0; r < 2; r++) begin
      {speedSel, crossoverAutoEnable, wakeCfg} = {r[0], 1'($urandom), 1'b1, r[0], r[0]};
      tick(6);
      check({asleep, writesEnabled, crossoverAuto}, 3'h0);
      check(sysReset, 3'h1);
      {srst, hwResetN} = 2'h1;
      for (int i = 0; i < 99 && sysReset !== 1'b0; i++) tick();
      check(sysReset, 3'h0);
      tick(2);
      check(linkSettings, {speedSel, 1'b0, speedSel});
      check(crossoverAuto, crossoverAutoEnable);
      // Always differs from the strap defaults, so a refused write shows
      linkWriteData = 3'({speedSel, 1'b0, speedSel} ^ (3'($urandom) | 3'h1));
      pulse(linkWrite);
      check(linkSettings, {speedSel, 1'b0, speedSel});
      i_host.access(1'b0);
      check(writesEnabled, 3'h1);
      pulse(linkWrite);
      check(linkSettings, linkWriteData);
      pulse(sleepRequest);
      check({asleep, writesEnabled}, 3'h2);
      pulse(wakeEvent);
      check(pinOn, 3'h1);
      i_host.access(1'b0);
      tick();
      check({asleep, pinOn}, 3'h3);
      i_host.access(1'b1);
      tick();
      check({asleep, pinOn}, 3'h0);
      hwResetN = 1'b0;
    end
    report_and_stop();
  end
  initial begin
    #9000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
